/* src/rst_ctrl_pkg.sv */
// Shared constants and types for the reset state controller
package rst_ctrl_pkg;

    typedef enum logic [1:0] {
        ST_HOLD,
        ST_RELEASE,
        ST_RUN,
        ST_STOP
    } state_t;

    localparam logic [7:0] PORT_LATCH_RST = 8'hff;
    localparam logic [7:0] PORT_PUSHPULL_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [7:0] SP_RST = 8'h07;
    localparam logic [1:0] CLK_SEL_INTERNAL = 2'h0;
    localparam logic IRQ_EN_RST = 1'b0;
    localparam logic TMR_EN_RST = 1'b0;
    localparam logic WDT_EN_RST = 1'b1;

    localparam int WDT_DIV = 12;
    localparam int WDT_CNT_W = 4;
    localparam logic [WDT_CNT_W-1:0] WDT_CNT_LAST = 4'hb;

    // Release lasts three cycles; covers the pin synchroniser latency
    localparam int REL_CNT_W = 2;
    localparam logic [REL_CNT_W-1:0] REL_CNT_LAST = 2'h2;

    // Synchroniser reset image: bit0 power-on, bit1 monitor, bit2 pin
    localparam logic [2:0] SRC_SYNC_RST = 3'h5;

endpackage

/* src/src_sync.sv */
// Two-flop synchroniser for asynchronous reset source inputs
`timescale 1ns/1ns
`default_nettype none
module src_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage1 <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // src_sync
`default_nettype wire

/* src/wdt_clk_div.sv */
// Watchdog time base: one tick every WDT_DIV system clocks
`timescale 1ns/1ns
`default_nettype none
module wdt_clk_div #(
    parameter int DIV = rst_ctrl_pkg::WDT_DIV
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic en_in,
    output logic tick_out
);
    logic [rst_ctrl_pkg::WDT_CNT_W-1:0] cnt;
    logic [rst_ctrl_pkg::WDT_CNT_W-1:0] last;
    logic wrap;

    assign last = rst_ctrl_pkg::WDT_CNT_W'(DIV - 1);
    assign wrap = en_in && (cnt == last);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt <= '0;
            tick_out <= 1'b0;
        end else begin
            cnt <= (!en_in || wrap) ? '0 : cnt + 1'b1;
            tick_out <= wrap;
        end
    end
endmodule // wdt_clk_div
`default_nettype wire

/* src/reset_state_ctrl.sv */
// Reset state controller: entry, hold, release and stop handling
`timescale 1ns/1ns
`default_nettype none
module reset_state_ctrl #(
    parameter int NPORT = 2,
    parameter int RAM_DEPTH = 256,
    parameter int RAM_AW = 8,
    parameter logic [7:0] SP_RESET = rst_ctrl_pkg::SP_RST
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic por_in,
    input wire logic vdd_mon_rst_in,
    input wire logic rst_pin_in,
    input wire logic wdt_rst_in,
    input wire logic sw_rst_in,
    input wire logic stop_req_in,
    input wire logic pc_step_in,
    input wire logic pc_load_in,
    input wire logic [15:0] pc_load_val_in,
    input wire logic sp_wr_in,
    input wire logic [7:0] sp_wdata_in,
    input wire logic ctl_wr_in,
    input wire logic [1:0] ctl_wdata_in,
    input wire logic clk_sel_wr_in,
    input wire logic [1:0] clk_sel_wdata_in,
    input wire logic wdt_dis_in,
    input wire logic port_wr_in,
    input wire logic port_mode_wr_in,
    input wire logic [$clog2(NPORT+1)-1:0] port_sel_in,
    input wire logic [7:0] port_wdata_in,
    input wire logic ram_we_in,
    input wire logic [RAM_AW-1:0] ram_addr_in,
    input wire logic [7:0] ram_wdata_in,
    output logic cpu_halt_out,
    output logic sfr_init_out,
    output logic fetch_en_out,
    output logic stop_out,
    output logic [15:0] pc_out,
    output logic [7:0] sp_out,
    output logic irq_en_out,
    output logic tmr_en_out,
    output logic [1:0] clk_sel_out,
    output logic wdt_en_out,
    output logic wdt_tick_out,
    output logic [NPORT*8-1:0] port_latch_out,
    output logic [NPORT*8-1:0] port_pushpull_out,
    output logic pullup_en_out,
    output logic rst_pin_o_out,
    output logic rst_pin_oe_out,
    output logic [7:0] ram_rdata_out
);
    rst_ctrl_pkg::state_t state;
    rst_ctrl_pkg::state_t next_state;
    logic [2:0] src_sync;
    logic por_s;
    logic vdd_s;
    logic pin_s;
    logic supply_cause;
    logic next_supply_cause;
    logic [rst_ctrl_pkg::REL_CNT_W-1:0] rel_cnt;
    logic ignore_pin;
    logic pin_src;
    logic supply_src;
    logic any_src;
    logic load_dflt;
    logic wr_ok;
    logic ram_write;
    logic wdt_run;
    logic [7:0] ram_word;
    logic [7:0] mem [RAM_DEPTH];

    src_sync #(
        .WIDTH(3),
        .RST_VAL(rst_ctrl_pkg::SRC_SYNC_RST)
    ) u_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .async_in({rst_pin_in, vdd_mon_rst_in, por_in}),
        .sync_out(src_sync)
    );

    assign por_s = src_sync[0];
    assign vdd_s = src_sync[1];
    assign pin_s = src_sync[2];

    // Our own drive of the pin must not re-trigger reset
    assign ignore_pin = rst_pin_oe_out || (state == rst_ctrl_pkg::ST_RELEASE);
    assign pin_src = !pin_s && !ignore_pin;
    assign supply_src = por_s || vdd_s;
    assign any_src = supply_src || pin_src || wdt_rst_in || sw_rst_in;

    // Reset state sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            rst_ctrl_pkg::ST_HOLD: begin
                if (!any_src) begin
                    next_state = rst_ctrl_pkg::ST_RELEASE;
                end
            end
            rst_ctrl_pkg::ST_RELEASE: begin
                if (any_src) begin
                    next_state = rst_ctrl_pkg::ST_HOLD;
                end else if (rel_cnt == rst_ctrl_pkg::REL_CNT_LAST) begin
                    next_state = rst_ctrl_pkg::ST_RUN;
                end
            end
            rst_ctrl_pkg::ST_RUN: begin
                if (any_src) begin
                    next_state = rst_ctrl_pkg::ST_HOLD;
                end else if (stop_req_in) begin
                    next_state = rst_ctrl_pkg::ST_STOP;
                end
            end
            rst_ctrl_pkg::ST_STOP: begin
                if (any_src) begin
                    next_state = rst_ctrl_pkg::ST_HOLD;
                end
            end
        endcase
    end

    assign load_dflt = (next_state == rst_ctrl_pkg::ST_HOLD);
    assign wr_ok = (state == rst_ctrl_pkg::ST_RUN) && !any_src;
    assign ram_write = ram_we_in && wr_ok;
    assign wdt_run = wdt_en_out && (state == rst_ctrl_pkg::ST_RUN);
    assign ram_word = mem[ram_addr_in];
    assign next_supply_cause = load_dflt ?
        (supply_cause || supply_src) : 1'b0;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= rst_ctrl_pkg::ST_HOLD;
            rel_cnt <= '0;
            supply_cause <= 1'b1;
        end else begin
            state <= next_state;
            rel_cnt <= (state == rst_ctrl_pkg::ST_RELEASE) ?
                rel_cnt + 1'b1 : '0;
            supply_cause <= next_supply_cause;
        end
    end

    // Core control lines follow the next state
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cpu_halt_out <= 1'b1;
            sfr_init_out <= 1'b1;
            fetch_en_out <= 1'b0;
            stop_out <= 1'b0;
        end else begin
            cpu_halt_out <= (next_state != rst_ctrl_pkg::ST_RUN);
            sfr_init_out <= load_dflt;
            fetch_en_out <= (next_state == rst_ctrl_pkg::ST_RUN);
            stop_out <= (next_state == rst_ctrl_pkg::ST_STOP);
        end
    end

    // Pin drive only during a hold with a power-on or supply monitor cause, released before run
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_pin_oe_out <= 1'b1;
            rst_pin_o_out <= 1'b0;
            pullup_en_out <= 1'b1;
        end else begin
            rst_pin_oe_out <= load_dflt && next_supply_cause;
            rst_pin_o_out <= 1'b0;
            pullup_en_out <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pc_out <= rst_ctrl_pkg::PC_RST;
        end else if (load_dflt) begin
            pc_out <= rst_ctrl_pkg::PC_RST;
        end else if (wr_ok && pc_load_in) begin
            pc_out <= pc_load_val_in;
        end else if (wr_ok && pc_step_in) begin
            pc_out <= pc_out + 16'h0001;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sp_out <= SP_RESET;
        end else if (load_dflt) begin
            sp_out <= SP_RESET;
        end else if (wr_ok && sp_wr_in) begin
            sp_out <= sp_wdata_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_en_out <= rst_ctrl_pkg::IRQ_EN_RST;
            tmr_en_out <= rst_ctrl_pkg::TMR_EN_RST;
        end else if (load_dflt) begin
            irq_en_out <= rst_ctrl_pkg::IRQ_EN_RST;
            tmr_en_out <= rst_ctrl_pkg::TMR_EN_RST;
        end else if (wr_ok && ctl_wr_in) begin
            irq_en_out <= ctl_wdata_in[0];
            tmr_en_out <= ctl_wdata_in[1];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clk_sel_out <= rst_ctrl_pkg::CLK_SEL_INTERNAL;
            wdt_en_out <= rst_ctrl_pkg::WDT_EN_RST;
        end else if (load_dflt) begin
            clk_sel_out <= rst_ctrl_pkg::CLK_SEL_INTERNAL;
            wdt_en_out <= rst_ctrl_pkg::WDT_EN_RST;
        end else begin
            if (wr_ok && clk_sel_wr_in) begin
                clk_sel_out <= clk_sel_wdata_in;
            end
            if (wr_ok && wdt_dis_in) begin
                wdt_en_out <= 1'b0;
            end
        end
    end

    // Port latches and output modes
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            port_latch_out <= {NPORT{rst_ctrl_pkg::PORT_LATCH_RST}};
            port_pushpull_out <= {NPORT{rst_ctrl_pkg::PORT_PUSHPULL_RST}};
        end else if (load_dflt) begin
            port_latch_out <= {NPORT{rst_ctrl_pkg::PORT_LATCH_RST}};
            port_pushpull_out <= {NPORT{rst_ctrl_pkg::PORT_PUSHPULL_RST}};
        end else begin
            for (int i = 0; i < NPORT; i++) begin
                if (wr_ok && port_wr_in && (int'(port_sel_in) == i)) begin
                    port_latch_out[i*8 +: 8] <= port_wdata_in;
                end
                if (wr_ok && port_mode_wr_in && (int'(port_sel_in) == i)) begin
                    port_pushpull_out[i*8 +: 8] <= port_wdata_in;
                end
            end
        end
    end

    // Data memory has no reset so its contents survive
    always_ff @(posedge clk_in) begin
        if (ram_write) begin
            mem[ram_addr_in] <= ram_wdata_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ram_rdata_out <= 8'h00;
        end else begin
            ram_rdata_out <= ram_word;
        end
    end

    wdt_clk_div #(
        .DIV(rst_ctrl_pkg::WDT_DIV)
    ) u_wdt_div (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .en_in(wdt_run),
        .tick_out(wdt_tick_out)
    );

    property p_halt;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state == rst_ctrl_pkg::ST_HOLD) |-> cpu_halt_out && sfr_init_out;
    endproperty
    a_halt: assert property (p_halt)
        else $error("core not halted in reset hold");

    property p_quiet;
        @(posedge clk_in) disable iff (!rst_n_in)
        sfr_init_out |-> !irq_en_out && !tmr_en_out;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("interrupts or timers enabled in reset");

    // Memory cells start unknown, so guard the write gate, not the data
    property p_ram_keep;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state != rst_ctrl_pkg::ST_RUN) |-> !ram_write;
    endproperty
    a_ram_keep: assert property (p_ram_keep)
        else $error("data memory changed during reset");

    property p_sp;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state == rst_ctrl_pkg::ST_HOLD) |=> (sp_out == SP_RESET);
    endproperty
    a_sp: assert property (p_sp)
        else $error("stack pointer not at default");

    property p_port;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state == rst_ctrl_pkg::ST_HOLD) |=>
            (&port_latch_out) && (port_pushpull_out == '0);
    endproperty
    a_port: assert property (p_port)
        else $error("ports not all ones open-drain");

    property p_pullup;
        @(posedge clk_in) disable iff (!rst_n_in)
        $changed(state) |=> pullup_en_out[*2];
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("weak pull-ups dropped");

    property p_pin_drive;
        @(posedge clk_in) disable iff (!rst_n_in)
        (load_dflt && supply_src) |=> rst_pin_oe_out && !rst_pin_o_out;
    endproperty
    a_pin_drive: assert property (p_pin_drive)
        else $error("reset pin not driven low");

    property p_pin_free;
        @(posedge clk_in) disable iff (!rst_n_in)
        fetch_en_out |-> !rst_pin_oe_out;
    endproperty
    a_pin_free: assert property (p_pin_free)
        else $error("reset pin driven while running");

    property p_pc_zero;
        @(posedge clk_in) disable iff (!rst_n_in)
        $rose(fetch_en_out) |-> (pc_out == rst_ctrl_pkg::PC_RST);
    endproperty
    a_pc_zero: assert property (p_pc_zero)
        else $error("first fetch not from address zero");

    property p_clk_int;
        @(posedge clk_in) disable iff (!rst_n_in)
        $rose(fetch_en_out) |->
            (clk_sel_out == rst_ctrl_pkg::CLK_SEL_INTERNAL) && wdt_en_out;
    endproperty
    a_clk_int: assert property (p_clk_int)
        else $error("clock or watchdog not at default on exit");

    property p_wdt_tick;
        @(posedge clk_in) disable iff (!rst_n_in)
        wdt_tick_out |=> (!wdt_tick_out)[*8] ##1 (!wdt_tick_out)[*3];
    endproperty
    a_wdt_tick: assert property (p_wdt_tick)
        else $error("watchdog tick faster than one in twelve");

    property p_stop_end;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state == rst_ctrl_pkg::ST_STOP) && any_src |=>
            (state == rst_ctrl_pkg::ST_HOLD) && !stop_out;
    endproperty
    a_stop_end: assert property (p_stop_end)
        else $error("reset did not end stop state");

    property p_hold;
        @(posedge clk_in) disable iff (!rst_n_in)
        any_src |=> cpu_halt_out;
    endproperty
    a_hold: assert property (p_hold)
        else $error("reset source active but core running");

    property p_release;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state == rst_ctrl_pkg::ST_HOLD) && !any_src ##1 !any_src[*3]
            |=> fetch_en_out;
    endproperty
    a_release: assert property (p_release)
        else $error("release not completed in three cycles");

endmodule // reset_state_ctrl
`default_nettype wire

/* testbench/core_model.sv */
// Processor core model: steps the program counter and notes each first fetch
`timescale 1ns/1ns
`default_nettype none
module core_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic go_in,
    input wire logic fetch_en_in,
    input wire logic [15:0] pc_in,
    output logic step_out,
    output logic [15:0] fetch_pc_out
);
    logic was_fetch;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            step_out <= 1'b0;
            was_fetch <= 1'b0;
            fetch_pc_out <= 16'hffff;
        end else begin
            step_out <= go_in && fetch_en_in;
            was_fetch <= fetch_en_in;
            // Address presented on the first fetch after each release
            if (fetch_en_in && !was_fetch) begin
                fetch_pc_out <= pc_in;
            end else if (!fetch_en_in) begin
                fetch_pc_out <= 16'hffff;
            end
        end
    end
endmodule // core_model
`default_nettype wire

/* testbench/reset_state_ctrl_tb.sv */
// Self-checking testbench for the reset state controller
`timescale 1ns/1ns
`default_nettype none
module reset_state_ctrl_tb;
    logic clk_in, rst_n_in, por, vdd, ext_rst_n, wdt_rst, sw_rst, stop_req;
    logic pc_load, sp_wr, ctl_wr, clk_sel_wr, wdt_dis, port_wr, port_mode_wr;
    logic ram_we, go, step, rst_pin;
    logic [15:0] pc_load_val, fetch_pc;
    logic [7:0] sp_wdata, port_wdata, ram_addr, ram_wdata;
    logic [1:0] ctl_wdata, clk_sel_wdata, port_sel;
    logic cpu_halt_out, sfr_init_out, fetch_en_out, stop_out, irq_en_out;
    logic tmr_en_out, wdt_en_out, wdt_tick_out, pullup_en_out;
    logic rst_pin_o_out, rst_pin_oe_out;
    logic [15:0] pc_out, port_latch_out, port_pushpull_out;
    logic [7:0] sp_out, ram_rdata_out;
    logic [1:0] clk_sel_out;
    int errors = 0;
    int checked = 0;

    // Reset pin wire: device pull-down drive, else external pull-up
    assign rst_pin = rst_pin_oe_out ? rst_pin_o_out : ext_rst_n;

    reset_state_ctrl dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .por_in(por), .vdd_mon_rst_in(vdd), .rst_pin_in(rst_pin),
        .wdt_rst_in(wdt_rst), .sw_rst_in(sw_rst), .stop_req_in(stop_req),
        .pc_step_in(step), .pc_load_in(pc_load), .pc_load_val_in(pc_load_val),
        .sp_wr_in(sp_wr), .sp_wdata_in(sp_wdata), .ctl_wr_in(ctl_wr),
        .ctl_wdata_in(ctl_wdata), .clk_sel_wr_in(clk_sel_wr),
        .clk_sel_wdata_in(clk_sel_wdata), .wdt_dis_in(wdt_dis),
        .port_wr_in(port_wr), .port_mode_wr_in(port_mode_wr),
        .port_sel_in(port_sel), .port_wdata_in(port_wdata),
        .ram_we_in(ram_we), .ram_addr_in(ram_addr),
        .ram_wdata_in(ram_wdata), .cpu_halt_out(cpu_halt_out),
        .sfr_init_out(sfr_init_out), .fetch_en_out(fetch_en_out),
        .stop_out(stop_out), .pc_out(pc_out), .sp_out(sp_out),
        .irq_en_out(irq_en_out), .tmr_en_out(tmr_en_out),
        .clk_sel_out(clk_sel_out), .wdt_en_out(wdt_en_out),
        .wdt_tick_out(wdt_tick_out), .port_latch_out(port_latch_out),
        .port_pushpull_out(port_pushpull_out),
        .pullup_en_out(pullup_en_out), .rst_pin_o_out(rst_pin_o_out),
        .rst_pin_oe_out(rst_pin_oe_out), .ram_rdata_out(ram_rdata_out));

    core_model core (.clk_in(clk_in), .rst_n_in(rst_n_in), .go_in(go),
        .fetch_en_in(fetch_en_out), .pc_in(pc_out), .step_out(step),
        .fetch_pc_out(fetch_pc));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic chk(input string n, input logic [15:0] s,
                       input logic [15:0] e);
        checked++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Every output that reset must force except stop_out, with the pin drive expected
    task automatic chk_def(input logic oe);
        chk("halt", cpu_halt_out, 1'b1);
        chk("sfr_init", sfr_init_out, 1'b1);
        chk("fetch", fetch_en_out, 1'b0);
        chk("irq", irq_en_out, rst_ctrl_pkg::IRQ_EN_RST);
        chk("tmr", tmr_en_out, rst_ctrl_pkg::TMR_EN_RST);
        chk("sp", sp_out, rst_ctrl_pkg::SP_RST);
        chk("pc", pc_out, rst_ctrl_pkg::PC_RST);
        chk("latch", port_latch_out, 16'hffff);
        chk("pushpull", port_pushpull_out, 16'h0000);
        chk("pullup", pullup_en_out, 1'b1);
        chk("clk_sel", clk_sel_out, rst_ctrl_pkg::CLK_SEL_INTERNAL);
        chk("wdt_en", wdt_en_out, 1'b1);
        chk("pin_oe", rst_pin_oe_out, oe);
        chk("pin_o", rst_pin_o_out, 1'b0);
    endtask

    task automatic wait_run();
        int n;
        n = 0;
        while (fetch_en_out !== 1'b1 && n < 20) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        chk("run", fetch_en_out, 1'b1);
        chk("pin_oe", rst_pin_oe_out, 1'b0);
        chk("pullup", pullup_en_out, 1'b1);
    endtask

    task automatic t_por();
        repeat (2) @(posedge clk_in);
        #1;
        chk_def(1'b1);
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        wait_run();
        @(posedge clk_in);
        #1;
        chk("first_fetch", fetch_pc, 16'h0000);
        $display("power-on test done");
    endtask

    task automatic t_sw();
        @(posedge clk_in);
        {sp_wr, ctl_wr, clk_sel_wr, port_wr, ram_we} <= 5'h1f;
        {pc_load, wdt_dis} <= 2'h3;
        sp_wdata <= 8'h30;
        ctl_wdata <= 2'h3;
        clk_sel_wdata <= 2'h2;
        port_sel <= 2'h0;
        port_wdata <= 8'h55;
        ram_addr <= 8'h10;
        ram_wdata <= 8'ha5;
        pc_load_val <= 16'h1234;
        @(posedge clk_in);
        {sp_wr, ctl_wr, clk_sel_wr, port_wr, ram_we} <= 5'h00;
        {pc_load, wdt_dis, port_mode_wr} <= 3'h1;
        port_sel <= 2'h1;
        port_wdata <= 8'hff;
        @(posedge clk_in);
        port_mode_wr <= 1'b0;
        #1;
        chk("sp_w", sp_out, 16'h0030);
        chk("pc_w", pc_out, 16'h1234);
        chk("latch_w", port_latch_out, 16'hff55);
        chk("pp_w", port_pushpull_out, 16'hff00);
        chk("wdt_off", wdt_en_out, 1'b0);
        @(posedge clk_in);
        sw_rst <= 1'b1;
        @(posedge clk_in);
        sw_rst <= 1'b0;
        sp_wr <= 1'b1;
        sp_wdata <= 8'h44;
        #1;
        chk_def(1'b0);
        @(posedge clk_in);
        sp_wr <= 1'b0;
        wait_run();
        chk("sp_kept", sp_out, rst_ctrl_pkg::SP_RST);
        chk("ram", ram_rdata_out, 16'h00a5);
        @(posedge clk_in);
        #1;
        chk("first_fetch", fetch_pc, 16'h0000);
        $display("software reset test done");
    endtask

    task automatic t_wdt();
        int n;
        n = 0;
        @(posedge clk_in);
        go <= 1'b1;
        while (wdt_tick_out !== 1'b1 && n < 30) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        n = 0;
        do begin
            @(posedge clk_in);
            #1;
            n++;
        end while (wdt_tick_out !== 1'b1 && n < 30);
        chk("tick_gap", 16'(n), 16'(rst_ctrl_pkg::WDT_DIV));
        go <= 1'b0;
        $display("watchdog test done");
    endtask

    task automatic t_stop();
        @(posedge clk_in);
        stop_req <= 1'b1;
        @(posedge clk_in);
        stop_req <= 1'b0;
        #1;
        chk("stop", stop_out, 1'b1);
        chk("stop_halt", cpu_halt_out, 1'b1);
        @(posedge clk_in);
        vdd <= 1'b1;
        repeat (4) @(posedge clk_in);
        #1;
        chk("stop_end", stop_out, 1'b0);
        chk_def(1'b1);
        @(posedge clk_in);
        vdd <= 1'b0;
        wait_run();
        $display("stop test done");
    endtask

    task automatic t_hold();
        @(posedge clk_in);
        wdt_rst <= 1'b1;
        repeat (10) begin
            @(posedge clk_in);
            #1;
            chk("hold", cpu_halt_out, 1'b1);
        end
        @(posedge clk_in);
        wdt_rst <= 1'b0;
        wait_run();
        // External pin reset: core held, pin not driven by the device
        @(posedge clk_in);
        ext_rst_n <= 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        chk("pin_halt", cpu_halt_out, 1'b1);
        chk("pin_no_drive", rst_pin_oe_out, 1'b0);
        @(posedge clk_in);
        ext_rst_n <= 1'b1;
        wait_run();
        $display("held reset test done");
    endtask

    initial begin
        {rst_n_in, por, vdd, wdt_rst, sw_rst, stop_req, go} = 7'h00;
        {pc_load, sp_wr, ctl_wr, clk_sel_wr, wdt_dis} = 5'h00;
        {port_wr, port_mode_wr, ram_we} = 3'h0;
        ext_rst_n = 1'b1;
        pc_load_val = 16'h0000;
        {sp_wdata, port_wdata, ram_addr, ram_wdata} = 32'h0000_0000;
        {ctl_wdata, clk_sel_wdata, port_sel} = 6'h00;
        t_por();
        t_sw();
        t_wdt();
        t_stop();
        t_hold();
        wrap_up();
    end

    initial begin
        repeat (3000) @(posedge clk_in);
        errors++;
        wrap_up();
    end
endmodule // reset_state_ctrl_tb
`default_nettype wire
